/* File: inc/uci_pkg.sv */
// Package for the UART channel register front end and interrupt logic.
// Assumes a byte-wide parallel CPU bus with a 3-bit register address.
package uci_pkg;

	// Register addresses.
	localparam logic [2:0] ADDR_DATA   = 3'h0;
	localparam logic [2:0] ADDR_MASK   = 3'h1;
	localparam logic [2:0] ADDR_IDENT  = 3'h2;

	// Mask register bit positions.
	localparam int MSK_RX_DATA   = 0;
	localparam int MSK_TX_EMPTY  = 1;
	localparam int MSK_LINE      = 2;
	localparam int MSK_MODEM     = 3;
	localparam int MSK_SLEEP     = 4;
	localparam int MSK_STOP_CHAR = 5;
	localparam int MSK_RTS_RISE  = 6;
	localparam int MSK_CTS_RISE  = 7;

	// Reset values.
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] IDENT_RESET = 8'h01;

	// Identification codes for bits 5:0 in descending priority.
	localparam logic [5:0] ID_LINE     = 6'h06;
	localparam logic [5:0] ID_TIMEOUT  = 6'h0c;
	localparam logic [5:0] ID_RX_DATA  = 6'h04;
	localparam logic [5:0] ID_TX_EMPTY = 6'h02;
	localparam logic [5:0] ID_MODEM    = 6'h00;
	localparam logic [5:0] ID_STOP     = 6'h10;
	localparam logic [5:0] ID_FLOW     = 6'h20;
	localparam logic [5:0] ID_NONE     = 6'h01;

	// Number of interrupt sources.
	localparam int NUM_SRC = 7;

	// Index of each source in the pending vector, highest priority first.
	localparam int SRC_LINE    = 0;
	localparam int SRC_TIMEOUT = 1;
	localparam int SRC_RX_DATA = 2;
	localparam int SRC_TX      = 3;
	localparam int SRC_MODEM   = 4;
	localparam int SRC_STOP    = 5;
	localparam int SRC_FLOW    = 6;

	// Host bus access.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} uci_bus_t;

	// Raw event and level inputs from the channel logic.
	typedef struct packed {
		logic line_err;
		logic rx_timeout;
		logic rx_data;
		logic tx_empty_evt;
		logic modem_chg;
		logic stop_char;
		logic cts_rise;
		logic rts_rise;
		logic modem_read;
	} uci_src_t;

endpackage : uci_pkg

/* File: hw/uci_flag.sv */
// Sticky flag cell: set by a hardware event, cleared by an access.
// Assumes set and clear are single-cycle pulses in the clk_i domain.
`timescale 1ns/10ps
module uci_flag (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	logic flag_q;
	logic flag_d;

	// Set wins over a clear arriving in the same cycle.
	assign flag_d = set_i | (flag_q & ~clr_i);
	assign flag_o = flag_q;

	// Flag storage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule : uci_flag

/* File: hw/uci_top.sv */
// Register front end and prioritised interrupt logic of one UART channel.
// Assumes receive/transmit FIFOs, line and modem status sit outside and drive
// the source inputs; the host bus is synchronous to clk_i.
`timescale 1ns/10ps

// What this block does
// - Host write to data address pushes the byte toward the transmitter.
// - Reset leaves the receive and transmit data registers untouched.
// - Mask bit set unmasks its source; clear masks it.
// - Masked sources neither show in identification nor raise the interrupt, except a CTS or RTS rise flagged before its mask bit was cleared.
// - Mask bit 7 enables CTS rise interrupt only with enhanced enable.
// - Mask bit 6 enables RTS rise interrupt only with enhanced enable.
// - Mask bit 5 enables stop character interrupt only with enhanced enable.
// - Mask bit 4 selects sleep mode only with enhanced enable.
// - Mask bit 3 enables modem status change interrupt.
// - Mask bit 2 enables line status error interrupt.
// - Mask bit 1 enables transmit empty interrupt.
// - Mask bit 0 enables data available and receive timeout interrupts.
// - Pending sources are ranked; only the highest is reported.
// - Identification read freezes the reported indication during the read.
// - Events during that read are recorded but not shown until it ends, except a stop character or CTS or RTS rise, which that end clears.
// - Identification bits 7:6 mirror FIFO enable as 11 or 00.
// - Identification bit 5 reports a CTS or RTS rise.
// - Identification bit 4 reports a stop or special character match.
// - Identification bits 3:1 carry the source code, reset 000.
// - Identification bit 0 is one when nothing is pending.
// - Reading the data address returns the next received byte.
// - Source codes follow the fixed seven-level priority table.
// - Transmit empty clears on an identification read that reported it or on a data write; modem on modem read.
// - Receive timeout clears when the receive data is read.
module uci_top (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire uci_pkg::uci_bus_t bus_i,
	output logic [7:0]             rdata_o,
	input  wire logic [7:0]        rx_byte_i,
	output logic                   rx_pop_o,
	output logic [7:0]             tx_byte_o,
	output logic                   tx_push_o,
	input  wire uci_pkg::uci_src_t src_i,
	input  wire logic              enh_en_i,
	input  wire logic              fifo_en_i,
	output logic                   sleep_o,
	output logic                   channel_irq_out_o
);

	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] ident_q;
	logic       rd_ident_q;
	logic       tx_push_q;
	logic [7:0] rdata_q;

	// Bus decode.
	wire rd_data  = bus_i.rd & (bus_i.addr == uci_pkg::ADDR_DATA);
	wire wr_data  = bus_i.wr & (bus_i.addr == uci_pkg::ADDR_DATA);
	wire rd_mask  = bus_i.rd & (bus_i.addr == uci_pkg::ADDR_MASK);
	wire wr_mask  = bus_i.wr & (bus_i.addr == uci_pkg::ADDR_MASK);
	wire rd_ident = bus_i.rd & (bus_i.addr == uci_pkg::ADDR_IDENT);
	// Read end marks completion of an identification read.
	wire ident_end = rd_ident_q & ~rd_ident;

	// Enhanced-only mask bits are gated by the enhanced enable.
	wire en_cts   = mask_q[uci_pkg::MSK_CTS_RISE] & enh_en_i;
	wire en_rts   = mask_q[uci_pkg::MSK_RTS_RISE] & enh_en_i;
	wire en_stop  = mask_q[uci_pkg::MSK_STOP_CHAR] & enh_en_i;
	assign sleep_o = mask_q[uci_pkg::MSK_SLEEP] & enh_en_i;

	// Sticky flags for event-type sources.
	logic tx_flag;
	logic modem_flag;
	logic stop_flag;
	logic flow_flag;

	// Transmit empty clears on a completed identification read that reported it, or on a data write.
	uci_flag u_tx (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (src_i.tx_empty_evt),
		.clr_i  ((ident_end & (ident_q[5:0] == uci_pkg::ID_TX_EMPTY)) | wr_data),
		.flag_o (tx_flag)
	);
	// Modem status change clears on a modem status read.
	uci_flag u_modem (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (src_i.modem_chg),
		.clr_i  (src_i.modem_read),
		.flag_o (modem_flag)
	);
	// Stop or special character clears on identification read.
	uci_flag u_stop (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (src_i.stop_char),
		.clr_i  (ident_end),
		.flag_o (stop_flag)
	);
	// CTS or RTS rise clears on identification or modem status read.
	uci_flag u_flow (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  ((src_i.cts_rise & en_cts) | (src_i.rts_rise & en_rts)),
		.clr_i  (ident_end | src_i.modem_read),
		.flag_o (flow_flag)
	);

	// Masked pending vector, highest priority at index 0.
	logic [uci_pkg::NUM_SRC-1:0] pend;
	assign pend[uci_pkg::SRC_LINE]    = src_i.line_err & mask_q[uci_pkg::MSK_LINE];
	assign pend[uci_pkg::SRC_TIMEOUT] = src_i.rx_timeout & mask_q[uci_pkg::MSK_RX_DATA];
	assign pend[uci_pkg::SRC_RX_DATA] = src_i.rx_data & mask_q[uci_pkg::MSK_RX_DATA];
	assign pend[uci_pkg::SRC_TX]      = tx_flag & mask_q[uci_pkg::MSK_TX_EMPTY];
	assign pend[uci_pkg::SRC_MODEM]   = modem_flag & mask_q[uci_pkg::MSK_MODEM];
	assign pend[uci_pkg::SRC_STOP]    = stop_flag & en_stop;
	assign pend[uci_pkg::SRC_FLOW]    = flow_flag;

	// Priority encoder for the source code.
	logic [5:0] code;
	assign code = pend[uci_pkg::SRC_LINE]    ? uci_pkg::ID_LINE :
	              pend[uci_pkg::SRC_TIMEOUT] ? uci_pkg::ID_TIMEOUT :
	              pend[uci_pkg::SRC_RX_DATA] ? uci_pkg::ID_RX_DATA :
	              pend[uci_pkg::SRC_TX]      ? uci_pkg::ID_TX_EMPTY :
	              pend[uci_pkg::SRC_MODEM]   ? uci_pkg::ID_MODEM :
	              pend[uci_pkg::SRC_STOP]    ? uci_pkg::ID_STOP :
	              pend[uci_pkg::SRC_FLOW]    ? uci_pkg::ID_FLOW :
	                                           uci_pkg::ID_NONE;

	// Live identification value with FIFO-enable mirror.
	wire [7:0] ident_live = {{2{fifo_en_i}}, code};

	// Mask register write.
	assign mask_d = wr_mask ? bus_i.wdata : mask_q;

	// Control state with reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q     <= uci_pkg::MASK_RESET;
			ident_q    <= uci_pkg::IDENT_RESET;
			rd_ident_q <= 1'b0;
			tx_push_q  <= 1'b0;
		end else begin
			mask_q     <= mask_d;
			rd_ident_q <= rd_ident;
			tx_push_q  <= wr_data;
			// Capture the value shown on the first read cycle and hold it until the read ends.
			if (!rd_ident_q) begin
				ident_q <= ident_live;
			end
		end
	end

	// Data registers are not touched by reset.
	always_ff @(posedge clk_i) begin
		if (wr_data) begin
			tx_q <= bus_i.wdata;
		end
		if (rd_data) begin
			rx_q <= rx_byte_i;
		end
	end

	// Read data mux; identification shows the frozen value.
	logic [7:0] rsel;
	assign rsel = rd_data  ? rx_byte_i :
	              rd_mask  ? mask_q :
	              rd_ident ? (rd_ident_q ? ident_q : ident_live) :
	                         8'h00;

	// Registered read data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else if (bus_i.rd) begin
			rdata_q <= rsel;
		end
	end

	assign rdata_o           = rdata_q;
	assign tx_byte_o         = tx_q;
	assign tx_push_o         = tx_push_q;
	assign rx_pop_o          = rd_data;
	assign channel_irq_out_o = |pend;

	// Assertions.
	property p_irq_tracks;
		@(posedge clk_i) disable iff (rst_i) (pend == '0) |-> !channel_irq_out_o;
	endproperty
	a_irq_tracks: assert property (p_irq_tracks) else $error("irq high with nothing pending");

	property p_freeze;
		@(posedge clk_i) disable iff (rst_i) (rd_ident && $past(rd_ident)) |=> $stable(ident_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("indication changed during read");

	property p_push;
		@(posedge clk_i) disable iff (rst_i) wr_data |=> (tx_push_o && tx_byte_o == $past(bus_i.wdata));
	endproperty
	a_push: assert property (p_push) else $error("transmit byte not pushed");

	property p_mask_wr;
		@(posedge clk_i) disable iff (rst_i) wr_mask |=> mask_q == $past(bus_i.wdata);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

	property p_line_top;
		@(posedge clk_i) disable iff (rst_i) pend[0] |-> code == uci_pkg::ID_LINE;
	endproperty
	a_line_top: assert property (p_line_top) else $error("line status not top priority");

	property p_none;
		@(posedge clk_i) disable iff (rst_i) (pend == '0) |-> ident_live[0];
	endproperty
	a_none: assert property (p_none) else $error("bit 0 low with nothing pending");

	property p_fifo_bits;
		@(posedge clk_i) disable iff (rst_i) ident_live[7:6] == {2{fifo_en_i}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits do not mirror");

	property p_sleep;
		@(posedge clk_i) disable iff (rst_i) !enh_en_i |-> !sleep_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep without enhanced enable");

	property p_tx_clear;
		@(posedge clk_i) disable iff (rst_i) (wr_data && !src_i.tx_empty_evt) |=> !tx_flag;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx empty not cleared by write");

endmodule : uci_top

/* File: sim/uci_chan_model.sv */
// Channel-side model: receive FIFO head byte and receive timeout level.
// Assumes pop and timeout set are one-cycle pulses on clk_i.
`timescale 1ns/10ps
module uci_chan_model (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	input  wire logic  rx_pop_i,
	input  wire logic  tmo_set_i,
	output logic [7:0] rx_byte_o,
	output logic       rx_timeout_o
);
	// Each pop brings a new head byte and ends any timeout condition.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_byte_o    <= 8'h5a;
			rx_timeout_o <= 1'b0;
		end else begin
			if (rx_pop_i) rx_byte_o <= rx_byte_o * 8'h05 + 8'h3b;
			rx_timeout_o <= !rx_pop_i && (tmo_set_i || rx_timeout_o);
		end
	end
endmodule : uci_chan_model

/* File: sim/uci_top_bench.sv */
// Self-checking bench for the channel register front end and interrupt logic.
// Assumes uci_top and uci_chan_model; read data and pushes are checked at the falling edge.
`timescale 1ns/10ps
module uci_top_bench;
	localparam logic [2:0] A_D = uci_pkg::ADDR_DATA, A_M = uci_pkg::ADDR_MASK, A_I = uci_pkg::ADDR_IDENT;
	localparam logic [8:0] LINE = 9'h100, TMO = 9'h080, RXD = 9'h040, TXE = 9'h020, MDM = 9'h010;
	localparam logic [8:0] STP = 9'h008, CTS = 9'h004, RTS = 9'h002, MRD = 9'h001;
	localparam logic [8:0] TRG [8] = '{LINE, TMO, RXD, TXE, MDM, STP, CTS, RTS};
	localparam int         MB  [8] = '{2, 0, 0, 1, 3, 5, 7, 6};
	localparam logic [5:0] CD  [9] = '{uci_pkg::ID_LINE, uci_pkg::ID_TIMEOUT, uci_pkg::ID_RX_DATA,
		uci_pkg::ID_TX_EMPTY, uci_pkg::ID_MODEM, uci_pkg::ID_STOP, uci_pkg::ID_FLOW, uci_pkg::ID_FLOW,
		uci_pkg::ID_NONE};
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	uci_pkg::uci_bus_t bus = '0;
	uci_pkg::uci_src_t src_w;
	logic [8:0]        lv = '0, pls = '0;
	logic              enh_en = 1'b0, fifo_en = 1'b0, rd_prev = 1'b0;
	logic [7:0]        rdata, tx_byte, rx_byte, d, hd = 8'h5a;
	logic              rx_pop, tx_push, sleep, irq, tmo;
	logic [7:0]        exp_rd[$], exp_tx[$];
	int                fail_count = 0, n_checks = 0, cycles = 0;

	// Clock and the source vector, whose timeout bit comes from the model.
	always #50 clk_i = ~clk_i;
	assign src_w = uci_pkg::uci_src_t'({lv[8] | pls[8], tmo, lv[6:0] | pls[6:0]});

	uci_top uci_top_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .rx_byte_i(rx_byte),
		.rx_pop_o(rx_pop), .tx_byte_o(tx_byte), .tx_push_o(tx_push), .src_i(src_w), .enh_en_i(enh_en),
		.fifo_en_i(fifo_en), .sleep_o(sleep), .channel_irq_out_o(irq));
	uci_chan_model uci_chan_model_i (.clk_i(clk_i), .rst_i(rst_i), .rx_pop_i(rx_pop), .tmo_set_i(pls[7]),
		.rx_byte_o(rx_byte), .rx_timeout_o(tmo));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	function automatic logic [7:0] idv(input int k);
		return {{2{fifo_en}}, CD[k]};
	endfunction : idv

	// Holds one access for n edges, notes what each cycle must return, then releases the bus.
	task automatic op(input logic r, input logic [2:0] a, input logic [7:0] v, input int n = 1);
		bus <= '{rd: r, wr: !r, addr: a, wdata: v};
		repeat (n) begin
			if (r && a == A_D) begin
				exp_rd.push_back(hd);
				hd = hd * 8'h05 + 8'h3b;
			end else if (r) exp_rd.push_back(v);
			else if (a == A_D) exp_tx.push_back(v);
			@(posedge clk_i);
		end
		bus <= '0;
		@(posedge clk_i);
	endtask : op

	// Levels stay up until cleared; events last one cycle.
	task automatic trigger(input logic [8:0] t);
		if (|(t & (LINE | RXD))) lv <= t;
		else pls <= t;
		@(posedge clk_i);
		pls <= '0;
		@(posedge clk_i);
	endtask : trigger

	task automatic chk_irq(input logic e);
		@(negedge clk_i);
		check(8'(irq), 8'(e));
		@(posedge clk_i);
	endtask : chk_irq

	// Removes every source by its own clearing action, then expects nothing pending.
	task automatic clear_all();
		lv <= '0;
		trigger(MRD);
		d = 8'($urandom);
		op(1'b0, A_D, d);
		op(1'b1, A_D, 8'h00);
		op(1'b1, A_I, idv(8));
	endtask : clear_all

	// Compares each read and each transmit push against the oldest note.
	always @(negedge clk_i) begin
		if (rd_prev) check(rdata, exp_rd.pop_front());
		if (tx_push) check(tx_byte, exp_tx.pop_front());
		rd_prev = bus.rd && !rst_i;
	end

	// Cuts a hung run short.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(32'h3b58e915));
		fifo_en <= 1'($urandom);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, an ignored write to the identification place, unmapped reads.
		op(1'b1, A_M, uci_pkg::MASK_RESET);
		op(1'b0, A_I, 8'hff);
		for (int a = 2; a < 8; a++) op(1'b1, 3'(a), (a == 2) ? idv(8) : 8'h00);
		d = 8'($urandom);
		op(1'b0, A_M, d);
		op(1'b1, A_M, d);
		for (int e = 0; e < 2; e++) begin
			enh_en <= e[0];
			repeat (2) @(posedge clk_i);
			check(8'(sleep), 8'(d[4] & e[0]));
		end
		// Each source masked, then alone unmasked.
		for (int i = 0; i < 8; i++) begin
			for (int u = 0; u < 2; u++) begin
				op(1'b0, A_M, u ? 8'(1 << MB[i]) : ~8'(1 << MB[i]));
				trigger(TRG[i]);
				chk_irq(u[0]);
				op(1'b1, A_I, u ? idv(i) : idv(8));
				clear_all();
				chk_irq(1'b0);
			end
		end
		// Several pending at once: only the highest shows, then the next.
		op(1'b0, A_M, 8'hff);
		lv <= LINE | RXD;
		trigger(TMO);
		trigger(TXE | MDM);
		op(1'b1, A_I, idv(0));
		lv <= RXD;
		@(posedge clk_i);
		op(1'b1, A_I, idv(1));
		op(1'b1, A_D, 8'h00);
		op(1'b1, A_I, idv(2));
		lv <= '0;
		@(posedge clk_i);
		op(1'b1, A_I, idv(3));
		op(1'b1, A_I, idv(4));
		trigger(MRD);
		op(1'b1, A_I, idv(8));
		// A long identification read stays frozen while a new source arrives.
		fork
			op(1'b1, A_I, idv(8), 4);
			begin
				@(posedge clk_i);
				lv <= RXD;
			end
		join
		op(1'b1, A_I, idv(2));
		lv <= '0;
		// Back-to-back data writes and reads, then a reset that keeps the transmit byte.
		d = 8'($urandom);
		op(1'b0, A_D, d, 2);
		op(1'b1, A_D, 8'h00, 3);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		hd = 8'h5a;
		check(tx_byte, d);
		// Enhanced sources stay silent without the enhanced enable.
		enh_en <= 1'b0;
		op(1'b0, A_M, 8'hff);
		trigger(CTS | RTS | STP);
		chk_irq(1'b0);
		op(1'b1, A_I, idv(8));
		end_of_test();
	end
endmodule : uci_top_bench
